// *** verilog/host_lane_defines.vh ***
// Constants for the host bus lane decode front end.
// Assumes inclusion by bare name from the design file.
`ifndef HOST_LANE_DEFINES_VH
`define HOST_LANE_DEFINES_VH
// Lane select patterns, active low, bit 0 = lane 0
`define LANES_DWORD    4'h0
`define LANES_LOW_WORD 4'hC
`define LANES_HI_WORD  4'h3
`define LANES_BYTE0    4'hE
`define LANES_BYTE1    4'hD
`define LANES_BYTE2    4'hB
`define LANES_BYTE3    4'h7
// Default I/O base, address bits 15..4
`define IO_BASE_RESET  12'h030
// Cycles the register side may take before ready returns
`define ACCESS_WAIT    4'h2
`endif

// *** verilog/host_bus_lane_decode.v ***
// Host bus front end: lane selection, device claim, strobe timing, ready.
// Assumes register side behind reg_* ports; read and write strobes pass three-flop synchronisers, address and lanes do not.
`include "host_lane_defines.vh"
`default_nettype none
module host_bus_lane_decode #(
   parameter [11:0] IO_BASE = `IO_BASE_RESET
) (
   input  wire        clk,
   input  wire        rst_b,
   input  wire        local_bus_mode_n,
   input  wire [15:1] address,
   input  wire        address_qualifier,
   input  wire        lane_select0_n,
   input  wire        lane_select1_n,
   input  wire        lane_select2_n,
   input  wire        lane_select3_n,
   input  wire        read_strobe_n,
   input  wire        write_strobe_n,
   input  wire        address_strobe_n,
   input  wire        cycle_strobe_n,
   input  wire        write_not_read,
   input  wire        local_clock,
   input  wire [31:0] data_in,
   output reg  [31:0] data_out,
   output reg  [31:0] data_oe,
   output wire        device_claim_n,
   output reg         async_ready,
   output reg         reg_read,
   output reg         reg_write,
   output reg  [15:1] reg_address,
   output reg  [3:0]  reg_lanes,
   output reg  [31:0] reg_wdata,
   output reg         local_write,
   input  wire [31:0] reg_rdata,
   input  wire        reg_done
);
   // Decodes a lane pattern; zero means not a listed size
   function [3:0] lane_decode;
      input [3:0] sel_n;
      input       wide;
      begin
         lane_decode = 4'h0;
         if (wide) begin
            case (sel_n)
               `LANES_DWORD, `LANES_LOW_WORD, `LANES_HI_WORD,
               `LANES_BYTE0, `LANES_BYTE1, `LANES_BYTE2, `LANES_BYTE3: lane_decode = ~sel_n;
               default: lane_decode = 4'h0;
            endcase
         end else begin
            // Upper lanes tied inactive; only two bytes ever move
            lane_decode = {2'b00, ~sel_n[1:0]};
         end
      end
   endfunction

   wire       wide = ~local_bus_mode_n;
   wire [3:0] pin_lanes_n = {lane_select3_n, lane_select2_n, lane_select1_n, lane_select0_n};

   // Transparent latch on address strobe for local bus; I/O bus grounds it so always open
   reg [15:1] lat_addr;
   reg        lat_qual;
   reg [3:0]  lat_lanes_n;
   reg [15:1] hold_addr;
   reg        hold_qual;
   reg [3:0]  hold_lanes_n;
   always @* begin
      if (!address_strobe_n) begin
         lat_addr    = address;
         lat_qual    = address_qualifier;
         lat_lanes_n = pin_lanes_n;
      end else begin
         lat_addr    = hold_addr;
         lat_qual    = hold_qual;
         lat_lanes_n = hold_lanes_n;
      end
   end
   // Capture on address strobe rising edge
   always @(posedge address_strobe_n or negedge rst_b) begin
      if (!rst_b) begin
         hold_addr    <= 15'h0000;
         hold_qual    <= 1'b1;
         hold_lanes_n <= 4'hF;
      end else begin
         hold_addr    <= address;
         hold_qual    <= address_qualifier;
         hold_lanes_n <= pin_lanes_n;
      end
   end

   // Claim is combinational so it answers before any clock edge
   wire       match = (lat_addr[15:4] == IO_BASE) && !lat_qual;
   wire [3:0] lanes = lane_decode(lat_lanes_n, wide);
   wire       valid = match && (lanes != 4'h0);
   assign device_claim_n = ~match;

   // Direction sampled on first local clock with cycle strobe active
   reg cyc_seen;
   always @(posedge local_clock or negedge rst_b) begin
      if (!rst_b) begin
         cyc_seen    <= 1'b0;
         local_write <= 1'b0;
      end else begin
         cyc_seen <= !cycle_strobe_n;
         if (!cycle_strobe_n && !cyc_seen)
            local_write <= write_not_read;
      end
   end

   // Write data caught on strobe trailing edge, only selected lanes
   reg [31:0] wr_data;
   reg [3:0]  wr_lanes;
   reg [15:1] wr_addr;
   reg        wr_toggle;
   always @(posedge write_strobe_n or negedge rst_b) begin
      if (!rst_b) begin
         wr_data   <= 32'h00000000;
         wr_lanes  <= 4'h0;
         wr_addr   <= 15'h0000;
         wr_toggle <= 1'b0;
      end else if (valid) begin
         wr_data   <= data_in & {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
         wr_lanes  <= lanes;
         wr_addr   <= {lat_addr[15:2], wide ? 1'b0 : lat_addr[1]};
         wr_toggle <= ~wr_toggle;
      end
   end

   // Three-flop synchronisers for strobes and write event
   reg [2:0] rd_sync;
   reg [2:0] wt_sync;
   reg [2:0] tg_sync;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_sync <= 3'h7;
         wt_sync <= 3'h7;
         tg_sync <= 3'h0;
      end else begin
         rd_sync <= {rd_sync[1:0], read_strobe_n};
         wt_sync <= {wt_sync[1:0], write_strobe_n};
         tg_sync <= {tg_sync[1:0], wr_toggle};
      end
   end
   wire rd_active = !rd_sync[1] && !rd_sync[2];
   wire wr_event  = tg_sync[1] ^ tg_sync[2];
   wire strobe_sync = !rd_sync[1] || !wt_sync[1];

   // Ready handshake: drops at read strobe edge or once a write is handed on, returns on clock after done
   reg busy;
   reg rd_issued;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy        <= 1'b0;
         rd_issued   <= 1'b0;
         reg_read    <= 1'b0;
         reg_write   <= 1'b0;
         reg_address <= 15'h0000;
         reg_lanes   <= 4'h0;
         reg_wdata   <= 32'h00000000;
         data_out    <= 32'h00000000;
      end else begin
         reg_read  <= 1'b0;
         reg_write <= 1'b0;
         if (wr_event && !busy) begin
            reg_write   <= 1'b1;
            reg_address <= wr_addr;
            reg_lanes   <= wr_lanes;
            reg_wdata   <= wr_data;
            busy        <= 1'b1;
         end else if (rd_active && valid && !rd_issued && !busy) begin
            reg_read    <= 1'b1;
            reg_address <= {lat_addr[15:2], wide ? 1'b0 : lat_addr[1]};
            reg_lanes   <= lanes;
            rd_issued   <= 1'b1;
            busy        <= 1'b1;
         end else if (busy && reg_done) begin
            busy <= 1'b0;
            if (rd_issued)
               data_out <= reg_rdata;
         end
         if (!rd_active && !busy)
            rd_issued <= 1'b0;
      end
   end

   // Ready held low from read strobe leading edge (write: from hand-on) until completion clock
   reg pend;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         pend <= 1'b0;
      else
         pend <= busy && !reg_done;
   end
   always @* begin
      async_ready = 1'b1;
      if ((!read_strobe_n && valid && !(rd_issued && !busy)) || busy || pend)
         async_ready = 1'b0;
   end

   // Drive only selected lanes during a claimed read
   always @* begin
      data_oe = 32'h00000000;
      if (!read_strobe_n && valid)
         data_oe = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
   end
   wire unused_sync = strobe_sync;
endmodule // host_bus_lane_decode
`default_nettype wire

// *** dv/reg_side_model.sv ***
// Register side model behind the front end.
// Assumes one access at a time; answers after a set delay.
`default_nettype none
module reg_side_model (
   input  wire logic        clk, rst_b, reg_read, reg_write,
   input  wire logic [3:0]  delay,
   input  wire logic [31:0] value,
   output var  logic        reg_done,
   output var  logic [31:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // Answer later; data churns when idle so stale reads show
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         reg_done <= 1'b0;
         reg_rdata <= 32'h0;
      end else begin
         reg_done <= cnt == 1;
         reg_rdata <= (cnt == 1) ? value : ~reg_rdata;
         if (reg_read || reg_write) cnt <= delay + 1;
         else if (cnt > 0) cnt <= cnt - 1;
      end
   end
endmodule // reg_side_model
`default_nettype wire

// *** dv/hbld_properties.sv ***
// Port checker for the lane decode front end.
// Assumes I/O bus use, address strobe held low.
`default_nettype none
module hbld_chk #(parameter [11:0] IO_BASE = 12'h030) (
   input wire logic        clk, rst_b, local_bus_mode_n, address_qualifier,
   input wire logic        lane_select0_n, lane_select1_n, read_strobe_n, write_strobe_n,
   input wire logic        device_claim_n, async_ready, reg_read, reg_write, reg_done,
   input wire logic [15:1] address,
   input wire logic [31:0] data_oe,
   input wire logic [3:0]  reg_lanes
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire io_ok = local_bus_mode_n && !(lane_select0_n && lane_select1_n);
   claim_a: assert property (device_claim_n == !(address[15:4] == IO_BASE && !address_qualifier))
      else $error("claim wrong");
   qual_block_a: assert property (address_qualifier && $past(address_qualifier) |-> !reg_read && !reg_write)
      else $error("access while disabled");
   rd_start_a: assert property ($fell(read_strobe_n) && !device_claim_n && io_ok |-> ##[1:6] reg_read)
      else $error("read not started");
   wr_trail_a: assert property (reg_write |-> write_strobe_n && $past(write_strobe_n))
      else $error("write before strobe rise");
   rdy_drop_a: assert property ($fell(read_strobe_n) && !device_claim_n && io_ok |-> !async_ready)
      else $error("ready not dropped");
   rdy_back_a: assert property (reg_done |-> ##[1:2] async_ready)
      else $error("ready not back");
   lane_map_a: assert property (reg_read || reg_write |-> reg_lanes == {2'b00, ~lane_select1_n, ~lane_select0_n})
      else $error("lanes wrong");
   lane_oe_a: assert property (data_oe[31:16] == 0 && (data_oe[7:0] == 0 || !lane_select0_n && !read_strobe_n)
      && (data_oe[15:8] == 0 || !lane_select1_n && !read_strobe_n))
      else $error("lane driven");
endmodule // hbld_chk
bind host_bus_lane_decode hbld_chk #(.IO_BASE(IO_BASE)) chk_u (.*);
`default_nettype wire

// *** dv/host_bus_lane_decode_tb_top.sv ***
// Bench for the lane decode front end in I/O bus use.
// Assumes the register side model answers every access.
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t mismatch", $time); end end
module host_bus_lane_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] BASE = 12'h030;
   logic clk = 0, rst_b = 0, address_qualifier = 1, read_strobe_n = 1, write_strobe_n = 1;
   logic lane_select0_n = 1, lane_select1_n = 1, lane_select2_n = 1, lane_select3_n = 1;
   logic [15:1] address = 0, cap_a;
   logic [31:0] data_in = 0, value = 0, data_out, data_oe, reg_wdata, reg_rdata, cap_w;
   logic [3:0] delay = 1, reg_lanes, cap_l;
   logic device_claim_n, async_ready, reg_read, reg_write, reg_done;
   logic [15:1] reg_address;
   int error_cnt = 0, checked = 0, np = 0;
   always #4 clk = ~clk;
   // Unused local-bus pins tied off for I/O bus use; address strobe tied low to hold the latch open
   host_bus_lane_decode dut_u (.clk(clk), .rst_b(rst_b), .local_bus_mode_n(1'b1), .address(address),
      .address_qualifier(address_qualifier), .lane_select0_n(lane_select0_n), .lane_select1_n(lane_select1_n),
      .lane_select2_n(lane_select2_n), .lane_select3_n(lane_select3_n), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .address_strobe_n(1'b0), .cycle_strobe_n(1'b1), .write_not_read(1'b1),
      .local_clock(1'b1), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .device_claim_n(device_claim_n), .async_ready(async_ready), .reg_read(reg_read), .reg_write(reg_write),
      .reg_address(reg_address), .reg_lanes(reg_lanes), .reg_wdata(reg_wdata), .local_write(),
      .reg_rdata(reg_rdata), .reg_done(reg_done));
   reg_side_model side_u (.clk(clk), .rst_b(rst_b), .reg_read(reg_read), .reg_write(reg_write),
      .delay(delay), .value(value), .reg_done(reg_done), .reg_rdata(reg_rdata));
   // Record each access the design hands on
   always @(posedge clk) if (reg_read || reg_write) begin
      np++;
      cap_a = reg_address;
      cap_l = reg_lanes;
      cap_w = reg_wdata;
   end
   task automatic test_done;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic acc(input bit wr, input logic [15:1] a, input logic [1:0] l, input bit q, input bit ok);
      logic [15:0] m, d;
      int n0, t;
      m = {{8{~l[1]}}, {8{~l[0]}}};
      d = 16'($urandom);
      n0 = np;
      t = 0;
      // Host waits until the previous access has fully finished
      while (!async_ready) @(posedge clk);
      @(posedge clk);
      address <= a;
      address_qualifier <= q;
      {lane_select1_n, lane_select0_n} <= l;
      {lane_select3_n, lane_select2_n} <= 2'($urandom);
      data_in <= {d, d};
      value <= {d, d};
      delay <= 4'($urandom_range(1, 7));
      @(posedge clk);
      if (wr) write_strobe_n <= 0; else read_strobe_n <= 0;
      repeat (3) @(posedge clk);
      if (!wr) `CHK(data_oe, ok ? {16'h0, m} : 32'h0)
      write_strobe_n <= 1;
      while (!async_ready && t < 40) begin @(posedge clk); t++; end
      `CHK(t < 40, 1'b1)
      if (!wr && ok) `CHK(data_out[15:0] & m, d & m)
      read_strobe_n <= 1;
      repeat (8) @(posedge clk);
      `CHK(np - n0, int'(ok))
      if (ok) `CHK(cap_l, {2'b00, ~l})
      if (ok) `CHK(cap_a, a)
      if (ok && wr && !a[1]) `CHK(cap_w[15:0] & m, d & m)
   endtask
   // Main sequence: every lane pattern both ways, then refusals
   initial begin
      void'($urandom(32'hF23F));
      repeat (3) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
      `CHK(async_ready, 1'b1)
      for (int i = 0; i < 8; i++) acc(i[0], {BASE, 3'($urandom)}, i[2:1], 0, i[2:1] != 2'h3);
      acc(1, {BASE, 3'h2}, 2'h0, 1, 0);
      acc(0, {BASE ^ 12'h001, 3'h0}, 2'h0, 0, 0);
      test_done;
   end
   // Watchdog well beyond the expected run
   initial begin
      #50000;
      error_cnt++;
      test_done;
   end
endmodule // host_bus_lane_decode_tb_top
`default_nettype wire
